// ==== hdl/sync_2ff.sv ====
// sync_2ff.sv: two flip-flop synchroniser for pin levels
// assumes: inputs are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = ce_i ? async_i : meta_reg;
    sync_next = ce_i ? meta_reg : sync_reg;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ==== hdl/usart_slave_consts.svh ====
// usart_slave_consts.svh: register indices, bit positions, reset values
// assumes: byte address is four times the register index
`ifndef USART_SLAVE_CONSTS_SVH
`define USART_SLAVE_CONSTS_SVH

// register indices (byte address = index * 4)
`define IDX_PERIPHERAL_IRQ_FLAGS   8'h0C
`define IDX_RECEIVE_CTRL_STATUS    8'h18
`define IDX_TRANSMIT_HOLDING       8'h19
`define IDX_RECEIVE_BUFFER_READ    8'h1A
`define IDX_PERIPHERAL_IRQ_ENABLES 8'h8C
`define IDX_TRANSMIT_CTRL_STATUS   8'h98
`define IDX_BAUD_DIVISOR           8'h99

// receive control/status bits
`define POS_SERIAL_PORT_ENABLE     7
`define POS_NINE_BIT_RECEIVE       6
`define POS_SINGLE_RECEIVE_ENABLE  5
`define POS_CONT_RECEIVE_ENABLE    4
`define POS_ADDRESS_DETECT_ENABLE  3
`define POS_FRAMING_ERROR          2
`define POS_OVERRUN_ERROR          1
`define POS_RECEIVE_NINTH_BIT      0

// transmit control/status bits
`define POS_CLOCK_SOURCE_SELECT    7
`define POS_NINE_BIT_TRANSMIT      6
`define POS_TRANSMIT_ENABLE        5
`define POS_SYNC_MODE              4
`define POS_HIGH_BAUD              2
`define POS_SHIFT_REGISTER_EMPTY   1
`define POS_TRANSMIT_NINTH_BIT     0

// flag and enable bits
`define POS_PARALLEL_PORT_IRQ      7
`define POS_RECEIVE_DATA           5
`define POS_TRANSMIT_BUFFER_FREE   4

// writable masks and reset values
`define MASK_RX_CTRL_WRITE         8'hF8
`define MASK_TX_CTRL_WRITE         8'hF5
`define MASK_IRQ_ENABLES_WRITE     8'h7F
`define RST_RECEIVE_CTRL_STATUS    8'h00
`define RST_TRANSMIT_CTRL_STATUS   8'h02
`define RST_TRANSMIT_HOLDING       8'h00
`define RST_PERIPHERAL_IRQ_ENABLES 8'h00
`define RST_BAUD_DIVISOR           8'h00

// bit counts per word, minus one; receive buffer full word count
`define LAST_BIT_8                 4'h7
`define LAST_BIT_9                 4'h8
`define RX_FIFO_FULL               2'h2

`endif

// ==== hdl/usart_slave_pkg.sv ====
// usart_slave_pkg.sv: types of the synchronous slave serial port
// assumes: constants live in usart_slave_consts.svh
package usart_slave_pkg;
  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
  typedef logic [8:0] rx_word_t;
endpackage

// ==== hdl/usart_sync_slave.sv ====
// usart_sync_slave.sv: synchronous slave serial port, wishbone registers
// assumes: external master drives shift clock; classic wishbone master
// Behaviour
// - slave mode when clock source bit clear
// - shifting continues while core sleeps
// - first written word moves straight to shifter
// - second word waits, buffer-free flag stays clear
// - after shift-out, held word loads, flag sets
// - transmit flag with enable wakes the core
// - single-receive enable ignored in slave mode
// - continuous receive works during sleep
// - full word copied to buffer; with enable, wakes core
// - receive flag set on completion, gated interrupt
// - data sampled on falling shift clock edge
// - two-word buffer; third word overruns when full
// - receive flag clears when buffer empties
//
// Chosen here: the Wishbone slave port.
`include "usart_slave_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module usart_sync_slave (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        shared_clock_pin_i,
  input  wire logic        shared_data_pin_i,
  output logic             shared_data_pin_o,
  output logic             shared_data_pin_oe_o,
  output logic             wake_o
);
  logic [1:0]                     pins_s;
  logic                           clk_s;
  logic                           data_s;
  logic                           ack_reg,       ack_next;
  logic [31:0]                    dat_reg,       dat_next;
  logic [7:0]                     rx_ctrl_reg,   rx_ctrl_next;
  logic [7:0]                     tx_ctrl_reg,   tx_ctrl_next;
  logic [7:0]                     irq_en_reg,    irq_en_next;
  logic [7:0]                     baud_reg,      baud_next;
  logic [7:0]                     hold_reg,      hold_next;
  logic                           hold_full_reg, hold_full_next;
  usart_slave_pkg::tx_state_t     tx_state_reg,  tx_state_next;
  logic [8:0]                     tsr_reg,       tsr_next;
  logic [3:0]                     tx_cnt_reg,    tx_cnt_next;
  logic                           pin_o_reg,     pin_o_next;
  logic                           pin_oe_reg,    pin_oe_next;
  logic                           clk_prev_reg;
  logic [8:0]                     rsr_reg,       rsr_next;
  logic [3:0]                     rx_cnt_reg,    rx_cnt_next;
  usart_slave_pkg::rx_word_t      fifo_reg [0:1];
  usart_slave_pkg::rx_word_t      fifo_next [0:1];
  logic                           wr_ptr_reg,    wr_ptr_next;
  logic                           rd_ptr_reg,    rd_ptr_next;
  logic [1:0]                     count_reg,     count_next;
  logic                           overrun_error_bit_reg,      overrun_error_bit_next;
  logic                           wake_reg,      wake_next;
  logic                           active, tx_go, rx_go, fall, load, push;
  logic                           bus_req, bus_act, wr_en, tx_wr, pop, rx_done;
  logic                           transmit_buffer_free_flag, receive_data_flag;
  logic [3:0]                     tx_last, rx_last;
  logic [7:0]                     idx, wdat, rd_byte;
  usart_slave_pkg::rx_word_t      rx_head, rx_word;

  // pin synchroniser
  sync_2ff #(.WIDTH(2)) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .async_i    ({shared_clock_pin_i, shared_data_pin_i}),
    .sync_o     (pins_s)
  );
  assign clk_s  = pins_s[1];
  assign data_s = pins_s[0];

  assign active  = rx_ctrl_reg[`POS_SERIAL_PORT_ENABLE] & tx_ctrl_reg[`POS_SYNC_MODE]
                   & ~tx_ctrl_reg[`POS_CLOCK_SOURCE_SELECT];
  assign tx_go   = active & tx_ctrl_reg[`POS_TRANSMIT_ENABLE] & ~rx_ctrl_reg[`POS_CONT_RECEIVE_ENABLE];
  assign rx_go   = active & rx_ctrl_reg[`POS_CONT_RECEIVE_ENABLE];
  assign fall    = clk_prev_reg & ~clk_s;
  assign tx_last = tx_ctrl_reg[`POS_NINE_BIT_TRANSMIT] ? `LAST_BIT_9 : `LAST_BIT_8;
  assign rx_last = rx_ctrl_reg[`POS_NINE_BIT_RECEIVE] ? `LAST_BIT_9 : `LAST_BIT_8;
  assign idx     = wb_adr_i[9:2];
  assign wdat    = wb_dat_i[7:0];
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_act = wb_cyc_i & wb_stb_i & ack_reg;
  assign wr_en   = bus_act & wb_we_i & wb_sel_i[0];
  assign tx_wr   = wr_en & (idx == `IDX_TRANSMIT_HOLDING);
  assign pop     = bus_act & ~wb_we_i & (idx == `IDX_RECEIVE_BUFFER_READ) & (count_reg != 2'h0);
  assign rx_done = rx_go & fall & (rx_cnt_reg == rx_last);
  assign transmit_buffer_free_flag    = ~hold_full_reg;
  assign receive_data_flag    = count_reg != 2'h0;
  assign rx_head = fifo_reg[rd_ptr_reg];

  // register read mux
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `IDX_PERIPHERAL_IRQ_FLAGS: begin
        rd_byte[`POS_RECEIVE_DATA]         = receive_data_flag;
        rd_byte[`POS_TRANSMIT_BUFFER_FREE] = transmit_buffer_free_flag;
      end
      `IDX_RECEIVE_CTRL_STATUS: begin
        rd_byte                         = rx_ctrl_reg & `MASK_RX_CTRL_WRITE;
        rd_byte[`POS_OVERRUN_ERROR]     = overrun_error_bit_reg;
        rd_byte[`POS_RECEIVE_NINTH_BIT] = rx_head[8];
      end
      `IDX_RECEIVE_BUFFER_READ:    rd_byte = rx_head[7:0];
      `IDX_PERIPHERAL_IRQ_ENABLES: rd_byte = irq_en_reg;
      `IDX_TRANSMIT_CTRL_STATUS: begin
        rd_byte                            = tx_ctrl_reg & `MASK_TX_CTRL_WRITE;
        rd_byte[`POS_SHIFT_REGISTER_EMPTY] = tx_state_reg == usart_slave_pkg::TX_IDLE;
      end
      `IDX_BAUD_DIVISOR:           rd_byte = baud_reg;
      default:                     rd_byte = 8'h00;
    endcase
  end

  // next state of bus, registers and both shifters
  always_comb begin
    ack_next       = bus_req;
    dat_next       = bus_req ? {24'h000000, rd_byte} : dat_reg;
    rx_ctrl_next   = rx_ctrl_reg;
    tx_ctrl_next   = tx_ctrl_reg;
    irq_en_next    = irq_en_reg;
    baud_next      = baud_reg;
    hold_next      = hold_reg;
    hold_full_next = hold_full_reg;
    tx_state_next  = tx_state_reg;
    tsr_next       = tsr_reg;
    tx_cnt_next    = tx_cnt_reg;
    rsr_next       = rsr_reg;
    rx_cnt_next    = rx_cnt_reg;
    fifo_next      = fifo_reg;
    wr_ptr_next    = wr_ptr_reg;
    rd_ptr_next    = rd_ptr_reg;
    count_next     = count_reg;
    overrun_error_bit_next      = overrun_error_bit_reg;
    load           = 1'b0;
    push           = 1'b0;
    if (wr_en) begin
      case (idx)
        `IDX_RECEIVE_CTRL_STATUS:    rx_ctrl_next = wdat & `MASK_RX_CTRL_WRITE;
        `IDX_PERIPHERAL_IRQ_ENABLES: irq_en_next  = wdat & `MASK_IRQ_ENABLES_WRITE;
        `IDX_TRANSMIT_CTRL_STATUS:   tx_ctrl_next = wdat & `MASK_TX_CTRL_WRITE;
        `IDX_BAUD_DIVISOR:           baud_next    = wdat;
        default:                     baud_next    = baud_reg;
      endcase
    end
    // transmit path, shifts on falling edges of the synchronised pin clock
    if (!tx_go) begin
      tx_state_next = usart_slave_pkg::TX_IDLE;
    end else begin
      unique case (tx_state_reg)
        usart_slave_pkg::TX_IDLE:  load = hold_full_reg;
        usart_slave_pkg::TX_SHIFT: begin
          if (fall) begin
            if (tx_cnt_reg == tx_last) begin
              tx_state_next = usart_slave_pkg::TX_IDLE;
              load          = hold_full_reg;
            end else begin
              tsr_next    = {1'b0, tsr_reg[8:1]};
              tx_cnt_next = tx_cnt_reg + 4'h1;
            end
          end
        end
      endcase
    end
    if (load) begin
      tsr_next       = {tx_ctrl_reg[`POS_TRANSMIT_NINTH_BIT], hold_reg};
      tx_cnt_next    = 4'h0;
      tx_state_next  = usart_slave_pkg::TX_SHIFT;
      hold_full_next = 1'b0;
    end
    if (tx_wr) begin
      hold_next      = wdat;
      hold_full_next = 1'b1;
    end
    // receive path
    if (!rx_go) begin
      rx_cnt_next = 4'h0;
      if (!rx_ctrl_reg[`POS_CONT_RECEIVE_ENABLE]) begin
        overrun_error_bit_next = 1'b0;
      end
    end else if (fall) begin
      rsr_next = {data_s, rsr_reg[8:1]};
      if (rx_done) begin
        rx_cnt_next = 4'h0;
        if (overrun_error_bit_reg) begin
          push = 1'b0;
        end else if (count_reg == `RX_FIFO_FULL && !pop) begin
          overrun_error_bit_next = 1'b1;
        end else begin
          push = 1'b1;
        end
      end else begin
        rx_cnt_next = rx_cnt_reg + 4'h1;
      end
    end
    // word taken after the last bit has been shifted in
    rx_word = rx_ctrl_reg[`POS_NINE_BIT_RECEIVE] ? rsr_next : {1'b0, rsr_next[8:1]};
    if (push) begin
      fifo_next[wr_ptr_reg] = rx_word;
      wr_ptr_next           = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (!push && pop) begin
      count_next = count_reg - 2'h1;
    end
    pin_o_next  = tsr_next[0];
    pin_oe_next = tx_go;
    wake_next   = (receive_data_flag & irq_en_reg[`POS_RECEIVE_DATA])
                  | (transmit_buffer_free_flag & irq_en_reg[`POS_TRANSMIT_BUFFER_FREE]);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg       <= 1'b0;
      dat_reg       <= 32'h00000000;
      rx_ctrl_reg   <= `RST_RECEIVE_CTRL_STATUS;
      tx_ctrl_reg   <= `RST_TRANSMIT_CTRL_STATUS & `MASK_TX_CTRL_WRITE;
      irq_en_reg    <= `RST_PERIPHERAL_IRQ_ENABLES;
      baud_reg      <= `RST_BAUD_DIVISOR;
      hold_reg      <= `RST_TRANSMIT_HOLDING;
      hold_full_reg <= 1'b0;
      tx_state_reg  <= usart_slave_pkg::TX_IDLE;
      tsr_reg       <= 9'h000;
      tx_cnt_reg    <= 4'h0;
      pin_o_reg     <= 1'b0;
      pin_oe_reg    <= 1'b0;
      clk_prev_reg  <= 1'b0;
      rsr_reg       <= 9'h000;
      rx_cnt_reg    <= 4'h0;
      fifo_reg[0]   <= 9'h000;
      fifo_reg[1]   <= 9'h000;
      wr_ptr_reg    <= 1'b0;
      rd_ptr_reg    <= 1'b0;
      count_reg     <= 2'h0;
      overrun_error_bit_reg      <= 1'b0;
      wake_reg      <= 1'b0;
    end else if (ce_i) begin
      ack_reg       <= ack_next;
      dat_reg       <= dat_next;
      rx_ctrl_reg   <= rx_ctrl_next;
      tx_ctrl_reg   <= tx_ctrl_next;
      irq_en_reg    <= irq_en_next;
      baud_reg      <= baud_next;
      hold_reg      <= hold_next;
      hold_full_reg <= hold_full_next;
      tx_state_reg  <= tx_state_next;
      tsr_reg       <= tsr_next;
      tx_cnt_reg    <= tx_cnt_next;
      pin_o_reg     <= pin_o_next;
      pin_oe_reg    <= pin_oe_next;
      clk_prev_reg  <= clk_s;
      rsr_reg       <= rsr_next;
      rx_cnt_reg    <= rx_cnt_next;
      fifo_reg      <= fifo_next;
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      overrun_error_bit_reg      <= overrun_error_bit_next;
      wake_reg      <= wake_next;
    end
  end

  assign wb_ack_o             = ack_reg;
  assign wb_dat_o             = dat_reg;
  assign shared_data_pin_o    = pin_o_reg;
  assign shared_data_pin_oe_o = pin_oe_reg;
  assign wake_o               = wake_reg;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_slave_gate_idle: assert property (
    !active |=> tx_state_reg == usart_slave_pkg::TX_IDLE && rx_cnt_reg == 4'h0)
    else $error("shifters not idle outside slave mode");

  a_tx_first_load: assert property (
    tx_go && tx_state_reg == usart_slave_pkg::TX_IDLE && hold_full_reg && !tx_wr
    |=> tx_state_reg == usart_slave_pkg::TX_SHIFT && !hold_full_reg && tx_cnt_reg == 4'h0)
    else $error("first word did not move to shifter");

  a_tx_hold_wait: assert property (
    tx_go && tx_state_reg == usart_slave_pkg::TX_SHIFT && hold_full_reg && !fall
    |=> hold_full_reg && !transmit_buffer_free_flag)
    else $error("held word left too early");

  a_tx_chain_load: assert property (
    tx_go && tx_state_reg == usart_slave_pkg::TX_SHIFT && fall && tx_cnt_reg == tx_last
    && hold_full_reg && !tx_wr
    |=> tx_state_reg == usart_slave_pkg::TX_SHIFT && transmit_buffer_free_flag && tsr_reg[7:0] == $past(hold_reg))
    else $error("held word not chained after shift out");

  a_wake_source: assert property (
    wake_o |-> $past(receive_data_flag && irq_en_reg[`POS_RECEIVE_DATA])
               || $past(transmit_buffer_free_flag && irq_en_reg[`POS_TRANSMIT_BUFFER_FREE]))
    else $error("wake without enabled flag");

  a_single_rx_ignored: assert property (
    active && !rx_ctrl_reg[`POS_CONT_RECEIVE_ENABLE] && fall && !pop
    |=> rx_cnt_reg == 4'h0 && $stable(count_reg))
    else $error("reception without continuous enable");

  a_rx_falling_sample: assert property (
    rx_go && fall && !rx_done |=> rsr_reg[8] == $past(data_s) && rx_cnt_reg == $past(rx_cnt_reg) + 4'h1)
    else $error("receive bit not taken on falling edge");

  a_rx_word_stored: assert property (
    rx_done && !overrun_error_bit_reg && count_reg != `RX_FIFO_FULL && !pop
    |=> receive_data_flag && count_reg == $past(count_reg) + 2'h1)
    else $error("completed word not buffered");

  a_rx_overrun_set: assert property (
    rx_done && !overrun_error_bit_reg && count_reg == `RX_FIFO_FULL && !pop
    |=> overrun_error_bit_reg && count_reg == `RX_FIFO_FULL ##1 overrun_error_bit_reg || !rx_ctrl_reg[`POS_CONT_RECEIVE_ENABLE])
    else $error("overrun not flagged");

  a_rx_flag_clear: assert property (
    count_reg == 2'h1 && pop && !rx_done |=> !receive_data_flag)
    else $error("receive flag stuck after last read");
endmodule
`default_nettype wire

// ==== verification/sync_master_model.sv ====
// sync_master_model.sv: outside master that clocks the slave serial port
// assumes: bench resolves the data pin level from both drivers
`timescale 1ns/1ps
`default_nettype none
module sync_master_model (
  output logic      clk_o,
  output logic      dat_o,
  output logic      dat_oe_o,
  input  wire logic dat_i
);
  initial begin
    clk_o    = 1'b0;
    dat_o    = 1'b0;
    dat_oe_o = 1'b0;
  end
  // one frame, lsb first; clock stands low outside frames
  task automatic xfer(input int nbits, input logic [8:0] tx, input logic drive, output logic [8:0] rx);
    rx = 9'h000;
    #13;
    for (int i = 0; i < nbits; i++) begin
      clk_o = 1'b1;
      #50;
      dat_oe_o = drive;
      dat_o    = tx[i];
      #150;
      rx[i] = dat_i;
      clk_o = 1'b0;
      #200;
    end
    dat_oe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// tb_top.sv: self-checking bench of the synchronous slave serial port
// assumes: wishbone master here, shift clock from sync_master_model
`include "usart_slave_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [9:0]  adr       = 10'h000;
  logic [3:0]  sel       = 4'hF;
  logic [31:0] wdat      = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        m_clk;
  logic        m_d;
  logic        m_oe;
  logic        d_o;
  logic        d_oe;
  logic        wake;
  logic        last_q    = 1'b0;
  wire logic   pin;
  int          err_count = 0;
  int          checks    = 0;

  always #25 core_clk = ~core_clk;
  // undriven pin toggles rather than holding a stale level
  assign pin = d_oe ? d_o : (m_oe ? m_d : ~last_q);
  always @(posedge core_clk) last_q <= pin;

  usart_sync_slave DUT (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .shared_clock_pin_i(m_clk), .shared_data_pin_i(pin),
    .shared_data_pin_o(d_o), .shared_data_pin_oe_o(d_oe), .wake_o(wake)
  );
  sync_master_model M (.clk_o(m_clk), .dat_o(m_d), .dat_oe_o(m_oe), .dat_i(pin));

  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] rd);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h00_0000, wd};
    // the wait ends on ack; with no ack only the watchdog ends it
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    wb(idx, 1'b1, wd, d);
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [8:0] exp, input logic [7:0] m = 8'hFF);
    logic [7:0] d;
    wb(idx, 1'b0, 8'h00, d);
    chk(name, {1'b0, d & m}, exp);
  endtask

  function automatic logic [8:0] rx_ctrl_exp(input logic nine, input logic ovr, input logic b0);
    return {1'b0, 8'h90 | {1'b0, nine, 6'h00} | {6'h00, ovr, b0}};
  endfunction

  initial begin
    #2_000_000;
    err_count++;
    results();
  end

  initial begin
    logic [7:0] ri [8];
    logic [8:0] re [8];
    logic [8:0] w [3];
    logic [8:0] got;
    logic [7:0] txc;
    logic [7:0] bd;
    int         nb;
    ri = '{`IDX_PERIPHERAL_IRQ_FLAGS, `IDX_RECEIVE_CTRL_STATUS, `IDX_TRANSMIT_HOLDING, `IDX_RECEIVE_BUFFER_READ,
           `IDX_PERIPHERAL_IRQ_ENABLES, `IDX_TRANSMIT_CTRL_STATUS, `IDX_BAUD_DIVISOR, 8'h20};
    re = '{9'h010, 9'h000, 9'h000, 9'h000, 9'h000, 9'h002, 9'h000, 9'h000};
    void'($urandom(32'h826d));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) rdchk("reset_value", ri[i], re[i]);
    bd = 8'($urandom);
    wr(`IDX_BAUD_DIVISOR, bd);
    rdchk("baud", `IDX_BAUD_DIVISOR, {1'b0, bd});
    // write without the low byte lane is ignored
    sel <= 4'hE;
    wr(`IDX_BAUD_DIVISOR, ~bd);
    sel <= 4'hF;
    rdchk("baud_sel", `IDX_BAUD_DIVISOR, {1'b0, bd});
    wr(8'h20, 8'h5A);
    rdchk("unmapped", 8'h20, 9'h000);
    wr(`IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    rdchk("flags_ro", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h010);
    // transmit: two words queued back to back
    for (int nine = 0; nine < 2; nine++) begin
      nb = 8 + nine;
      for (int k = 0; k < 2; k++) w[k] = 9'($urandom) & {nine[0], 8'hFF};
      w[1][8] = w[0][8];
      txc = 8'h30 | {1'b0, nine[0], 5'h00, w[0][8]};
      wr(`IDX_RECEIVE_CTRL_STATUS, 8'h80);
      wr(`IDX_TRANSMIT_CTRL_STATUS, txc);
      wr(`IDX_PERIPHERAL_IRQ_ENABLES, 8'h10);
      wr(`IDX_TRANSMIT_HOLDING, w[0][7:0]);
      wr(`IDX_TRANSMIT_HOLDING, w[1][7:0]);
      rdchk("tx_flags_held", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h000);
      rdchk("tx_ctrl_busy", `IDX_TRANSMIT_CTRL_STATUS, {1'b0, txc});
      chk("wake_held", {8'h00, wake}, 9'h000);
      M.xfer(nb, 9'h000, 1'b0, got);
      chk("tx_word_first", got, w[0]);
      rdchk("tx_flags_free", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h010);
      chk("wake_tx", {8'h00, wake}, 9'h001);
      M.xfer(nb, 9'h000, 1'b0, got);
      chk("tx_word_second", got, w[1]);
      rdchk("tx_ctrl_idle", `IDX_TRANSMIT_CTRL_STATUS, {1'b0, txc | 8'h02});
    end
    // receive: clock source set keeps the slave idle
    wr(`IDX_TRANSMIT_CTRL_STATUS, 8'h90);
    wr(`IDX_RECEIVE_CTRL_STATUS, 8'h90);
    M.xfer(8, 9'h05A, 1'b1, got);
    rdchk("rx_flags_clock_source_select", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h010);
    // receive: single enable alone must not receive
    wr(`IDX_TRANSMIT_CTRL_STATUS, 8'h10);
    wr(`IDX_RECEIVE_CTRL_STATUS, 8'hA0);
    M.xfer(8, 9'h0A5, 1'b1, got);
    rdchk("rx_flags_single", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h010);
    for (int nine = 0; nine < 2; nine++) begin
      nb = 8 + nine;
      for (int k = 0; k < 3; k++) w[k] = 9'($urandom) & {nine[0], 8'hFF};
      wr(`IDX_PERIPHERAL_IRQ_ENABLES, {2'b00, nine[0], 5'h00});
      wr(`IDX_RECEIVE_CTRL_STATUS, 8'h90 | {1'b0, nine[0], 6'h00});
      M.xfer(nb, w[0], 1'b1, got);
      rdchk("rx_flags_one", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h030);
      chk("wake_rx", {8'h00, wake}, {8'h00, nine[0]});
      M.xfer(nb, w[1], 1'b1, got);
      M.xfer(nb, w[2], 1'b1, got);
      rdchk("rx_ctrl_ovr", `IDX_RECEIVE_CTRL_STATUS, rx_ctrl_exp(nine[0], 1'b1, w[0][8]));
      rdchk("rx_data_first", `IDX_RECEIVE_BUFFER_READ, {1'b0, w[0][7:0]});
      rdchk("rx_ctrl_next", `IDX_RECEIVE_CTRL_STATUS, rx_ctrl_exp(nine[0], 1'b1, w[1][8]));
      rdchk("rx_data_second", `IDX_RECEIVE_BUFFER_READ, {1'b0, w[1][7:0]});
      rdchk("rx_flags_empty", `IDX_PERIPHERAL_IRQ_FLAGS, 9'h010);
      wr(`IDX_RECEIVE_CTRL_STATUS, 8'h80 | {1'b0, nine[0], 6'h00});
      rdchk("rx_ctrl_clear", `IDX_RECEIVE_CTRL_STATUS, {2'b01, nine[0], 6'h00}, 8'hFE);
    end
    results();
  end
endmodule
`default_nettype wire
